// ### rtl/gsrl_status.sv
// Bus status reporting, service request and interface message handling
`timescale 1ns/100ps
// Summary of operation
// - Eight-bit event enable mask, written 0..255, query returns stored value
// - Event bits: power-on 7, command 5, execution 4, alarm 3, complete 0
// - Event enable mask is zero after power-up and kept until rewritten or cleared by the reset command
// - Event status query returns the register then clears all its bits
// - Execution error sets event status bit 4
// - Status byte bit 5 is OR of enabled event status bits
// - Enabled status byte bit sets summary bit 6 and asserts service request
// - Only status byte bits 5, 4, 1, 0 can request service
// - Service request is signalled only on the bus interface
// - Status byte query shows summary in bit 6 and clears nothing
// - Serial poll shows request bit 6 and clears only that bit
// - Clear status clears event register and status byte, keeps output queue
// - Message available follows output queue, clears when queue fully read
// - Summary bit clears when all enabled status byte bits 5, 4, 1, 0 are clear
// - Interface clear drops talker and listener addressing and serial poll mode
// - Device clear flushes queues, drops address, request, status, goes local
// - Reset command flushes, clears request, status and masks, keeps remote
// - Power-up: unaddressed, empty, cleared status and masks, local, no lockout
// - Exactly one of local, remote, lockout; returns local on listed causes
// - Remote when listen-addressed with REN; keys locked per state
// - Acts on DCL SPE SPD LLO UNL UNT SDC GTL; ignores PPU PPC GET TCT
// - Request bit sets on summary rising, clears on summary clear or poll
module gsrl_status (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic POWER_ON,
	input wire logic [3:0] IF_MSG,
	input wire logic IF_MSG_VALID,
	input wire logic REN,
	input wire logic SERIAL_POLL_READ,
	input wire logic [2:0] CMD,
	input wire logic CMD_VALID,
	input wire logic CMD_RST,
	input wire logic [7:0] CMD_DATA,
	input wire logic EV_CMD_ERROR,
	input wire logic EV_EXEC_ERROR,
	input wire logic EV_ALARM,
	input wire logic EV_OP_COMPLETE,
	input wire logic LOCAL_BUS_EXEC_ERROR,
	input wire logic LOCAL_BUS_TIMEOUT,
	input wire logic OUT_QUEUE_NOT_EMPTY,
	input wire logic LOCAL_KEY,
	input wire logic ERROR_ACTIVE,
	output logic [7:0] RESP_DATA,
	output logic RESP_VALID,
	output logic [7:0] POLL_BYTE,
	output logic SRQ_N,
	output logic SRQ_OE_N,
	output logic TALKER,
	output logic LISTENER,
	output logic SERIAL_POLL_MODE,
	output logic FLUSH_BUFFERS,
	output logic [1:0] RL_STATE,
	output logic KEYS_LOCKED,
	output logic LOCAL_KEY_LOCKED
);
	gsrl_clr_if clr();
	gsrl_pkg::gsrl_rl_state_t rl_state;

	logic [7:0] esr_q;
	logic [7:0] ese_q;
	logic [7:0] sre_q;
	logic rqs_q;
	logic mss_q;
	logic talker_q;
	logic listener_q;
	logic spoll_q;
	logic llo_q;
	logic mav_hold_q;
	logic local_bus_exec_error_q;
	logic tmo_q;
	logic [7:0] resp_q;
	logic resp_valid_q;
	logic flush_q;

	function automatic logic msg_is(input logic [3:0] m, input logic [3:0] code);
		msg_is = IF_MSG_VALID && (m == code);
	endfunction : msg_is

	// Decoded interface messages; parallel poll, trigger and take control fall through
	wire m_dcl = msg_is(IF_MSG, gsrl_pkg::MSG_DCL);
	wire m_sdc = msg_is(IF_MSG, gsrl_pkg::MSG_SDC) && listener_q;
	wire m_spe = msg_is(IF_MSG, gsrl_pkg::MSG_SPE);
	wire m_spd = msg_is(IF_MSG, gsrl_pkg::MSG_SPD);
	wire m_llo = msg_is(IF_MSG, gsrl_pkg::MSG_LLO);
	wire m_unl = msg_is(IF_MSG, gsrl_pkg::MSG_UNL);
	wire m_unt = msg_is(IF_MSG, gsrl_pkg::MSG_UNT);
	wire m_gtl = msg_is(IF_MSG, gsrl_pkg::MSG_GTL) && listener_q;
	wire m_mla = msg_is(IF_MSG, gsrl_pkg::MSG_MLA);
	wire m_mta = msg_is(IF_MSG, gsrl_pkg::MSG_MTA);
	wire m_ifc = msg_is(IF_MSG, gsrl_pkg::MSG_IFC);

	wire dev_clear = m_dcl | m_sdc;
	wire pwr = POWER_ON;
	wire cmd_ok = CMD_VALID;
	wire cls = cmd_ok && (CMD == gsrl_pkg::CMD_CLS);
	wire esr_read = cmd_ok && (CMD == gsrl_pkg::CMD_ESR_READ);
	wire ese_write = cmd_ok && (CMD == gsrl_pkg::CMD_ESE_WRITE);
	wire sre_write = cmd_ok && (CMD == gsrl_pkg::CMD_SRE_WRITE);
	wire stb_read = cmd_ok && (CMD == gsrl_pkg::CMD_STB_READ);
	// Status clear sources
	wire stat_clear = cls | dev_clear | CMD_RST | pwr;
	wire mask_clear = CMD_RST | pwr;
	wire addr_clear = m_ifc | dev_clear | CMD_RST | pwr;

	// Incoming events, set wins over clear
	logic [7:0] ev_set;
	always_comb
	begin
		ev_set = 8'h00;
		ev_set[gsrl_pkg::ESR_PON_BIT] = pwr;
		ev_set[gsrl_pkg::ESR_CME_BIT] = EV_CMD_ERROR;
		ev_set[gsrl_pkg::ESR_EXE_BIT] = EV_EXEC_ERROR;
		ev_set[gsrl_pkg::ESR_ALM_BIT] = EV_ALARM;
		ev_set[gsrl_pkg::ESR_OPC_BIT] = EV_OP_COMPLETE;
	end
	wire esr_clr = esr_read | stat_clear;
	wire [7:0] esr_d = ((esr_clr ? 8'h00 : esr_q) | ev_set) & gsrl_pkg::ESR_USED_MASK;

	// Local bus flags latch until status is cleared
	wire local_bus_exec_error_d = LOCAL_BUS_EXEC_ERROR | (local_bus_exec_error_q & ~stat_clear);
	wire tmo_d = LOCAL_BUS_TIMEOUT | (tmo_q & ~stat_clear);
	// Queue flush blanks message available for the flush cycle and the cycle after
	wire mav = OUT_QUEUE_NOT_EMPTY & ~flush_q & ~mav_hold_q;

	wire esb = |(esr_q & ese_q);
	logic [7:0] stb;
	always_comb
	begin
		stb = 8'h00;
		stb[gsrl_pkg::STB_ESB_BIT] = esb;
		stb[gsrl_pkg::STB_MAV_BIT] = mav;
		stb[gsrl_pkg::STB_LOCAL_BUS_EXEC_ERROR_BIT] = local_bus_exec_error_q;
		stb[gsrl_pkg::STB_TMO_BIT] = tmo_q;
	end
	wire mss_d = |(stb & sre_q & gsrl_pkg::STB_SRQ_SOURCES);
	// Summary falls once all enabled sources are gone
	wire rqs_set = mss_d & ~mss_q;
	wire rqs_clr = ~mss_d | SERIAL_POLL_READ | dev_clear | CMD_RST | pwr;

	wire [7:0] stb_query = stb | ({7'h00, mss_q} << gsrl_pkg::STB_RQS_BIT);
	wire [7:0] poll_d = stb | ({7'h00, rqs_q} << gsrl_pkg::STB_RQS_BIT);

	logic [7:0] resp_d;
	always_comb
	begin
		case (CMD)
			gsrl_pkg::CMD_ESE_READ: resp_d = ese_q;
			gsrl_pkg::CMD_ESR_READ: resp_d = esr_q;
			gsrl_pkg::CMD_SRE_READ: resp_d = sre_q;
			gsrl_pkg::CMD_STB_READ: resp_d = stb_query;
			default: resp_d = 8'h00;
		endcase
	end
	wire is_query = esr_read | stb_read | (cmd_ok && (CMD == gsrl_pkg::CMD_ESE_READ)) |
		(cmd_ok && (CMD == gsrl_pkg::CMD_SRE_READ));

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			esr_q <= 8'h00;
			ese_q <= gsrl_pkg::EVENT_ENABLE_RESET;
			sre_q <= gsrl_pkg::SERVICE_ENABLE_RESET;
			local_bus_exec_error_q <= 1'b0;
			tmo_q <= 1'b0;
		end
		else
		begin
			esr_q <= esr_d;
			local_bus_exec_error_q <= local_bus_exec_error_d;
			tmo_q <= tmo_d;
			if (mask_clear)
				ese_q <= gsrl_pkg::EVENT_ENABLE_RESET;
			else if (ese_write)
				ese_q <= CMD_DATA;
			if (mask_clear)
				sre_q <= gsrl_pkg::SERVICE_ENABLE_RESET;
			else if (sre_write)
				sre_q <= CMD_DATA;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			mss_q <= 1'b0;
			rqs_q <= 1'b0;
			mav_hold_q <= 1'b0;
			flush_q <= 1'b0;
		end
		else
		begin
			mss_q <= mss_d & ~(dev_clear | CMD_RST | pwr);
			rqs_q <= rqs_set | (rqs_q & ~rqs_clr);
			flush_q <= dev_clear | CMD_RST | pwr;
			mav_hold_q <= flush_q;
		end
	end

	// Addressing, serial poll and lockout message state
	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			talker_q <= 1'b0;
			listener_q <= 1'b0;
			spoll_q <= 1'b0;
			llo_q <= 1'b0;
		end
		else
		begin
			if (addr_clear || m_unl || m_mta)
				listener_q <= m_mta ? listener_q & ~addr_clear : 1'b0;
			else if (m_mla)
				listener_q <= 1'b1;
			if (addr_clear || m_unt)
				talker_q <= 1'b0;
			else if (m_mta)
				talker_q <= 1'b1;
			if (m_ifc || pwr || m_spd)
				spoll_q <= 1'b0;
			else if (m_spe)
				spoll_q <= 1'b1;
			if (dev_clear || pwr || !REN)
				llo_q <= 1'b0;
			else if (m_llo)
				llo_q <= 1'b1;
		end
	end

	always_ff @(posedge CLK)
	begin
		if (RESET)
		begin
			resp_q <= 8'h00;
			resp_valid_q <= 1'b0;
		end
		else
		begin
			resp_valid_q <= is_query;
			if (is_query)
				resp_q <= resp_d;
		end
	end

	assign clr.power_up = pwr;
	assign clr.dev_clear = dev_clear;
	assign clr.rl_msg_local = m_gtl;
	assign clr.rl_msg_lockout = llo_q | m_llo;
	// Only the addressing event enters remote, so go-to-local is not undone next cycle
	assign clr.listen_addr = m_mla;

	gsrl_remote_local u_rl (
		.clk(CLK),
		.reset(RESET),
		.clr(clr),
		.ren(REN),
		.local_key(LOCAL_KEY),
		.error_active(ERROR_ACTIVE),
		.state(rl_state),
		.keys_locked(KEYS_LOCKED),
		.local_key_locked(LOCAL_KEY_LOCKED)
	);

	assign RESP_DATA = resp_q;
	assign RESP_VALID = resp_valid_q;
	assign POLL_BYTE = poll_d;
	// Open-drain request line, pulled low while requesting
	assign SRQ_N = 1'b0;
	assign SRQ_OE_N = ~rqs_q;
	assign TALKER = talker_q;
	assign LISTENER = listener_q;
	assign SERIAL_POLL_MODE = spoll_q;
	assign FLUSH_BUFFERS = flush_q;
	assign RL_STATE = rl_state;
endmodule : gsrl_status

// ### rtl/gsrl_pkg.sv
// Constants and types for the bus status and remote/local block
package gsrl_pkg;
	// Standard event status bit positions
	localparam int ESR_PON_BIT = 7;
	localparam int ESR_CME_BIT = 5;
	localparam int ESR_EXE_BIT = 4;
	localparam int ESR_ALM_BIT = 3;
	localparam int ESR_OPC_BIT = 0;
	localparam logic [7:0] ESR_USED_MASK = 8'hB9;
	// Status byte bit positions
	localparam int STB_RQS_BIT = 6;
	localparam int STB_ESB_BIT = 5;
	localparam int STB_MAV_BIT = 4;
	localparam int STB_LOCAL_BUS_EXEC_ERROR_BIT = 1;
	localparam int STB_TMO_BIT = 0;
	localparam logic [7:0] STB_SRQ_SOURCES = 8'h33;
	// Reset values
	localparam logic [7:0] EVENT_ENABLE_RESET = 8'h00;
	localparam logic [7:0] SERVICE_ENABLE_RESET = 8'h00;
	// Interface message codes on the interface message port
	localparam logic [3:0] MSG_NONE = 4'h0;
	localparam logic [3:0] MSG_DCL = 4'h1;
	localparam logic [3:0] MSG_SPE = 4'h2;
	localparam logic [3:0] MSG_SPD = 4'h3;
	localparam logic [3:0] MSG_PPU = 4'h4;
	localparam logic [3:0] MSG_LLO = 4'h5;
	localparam logic [3:0] MSG_UNL = 4'h6;
	localparam logic [3:0] MSG_UNT = 4'h7;
	localparam logic [3:0] MSG_SDC = 4'h8;
	localparam logic [3:0] MSG_PPC = 4'h9;
	localparam logic [3:0] MSG_GTL = 4'hA;
	localparam logic [3:0] MSG_GET = 4'hB;
	localparam logic [3:0] MSG_TCT = 4'hC;
	localparam logic [3:0] MSG_MLA = 4'hD;
	localparam logic [3:0] MSG_MTA = 4'hE;
	localparam logic [3:0] MSG_IFC = 4'hF;
	// Common command codes
	localparam logic [2:0] CMD_NONE = 3'h0;
	localparam logic [2:0] CMD_ESE_WRITE = 3'h1;
	localparam logic [2:0] CMD_ESE_READ = 3'h2;
	localparam logic [2:0] CMD_ESR_READ = 3'h3;
	localparam logic [2:0] CMD_SRE_WRITE = 3'h4;
	localparam logic [2:0] CMD_SRE_READ = 3'h5;
	localparam logic [2:0] CMD_STB_READ = 3'h6;
	localparam logic [2:0] CMD_CLS = 3'h7;
	typedef enum logic [1:0] {GSRL_LOCAL, GSRL_REMOTE, GSRL_LOCKOUT} gsrl_rl_state_t;
endpackage : gsrl_pkg

// ### rtl/gsrl_clr_if.sv
// Clear strobes shared between the top and the remote/local machine
`timescale 1ns/100ps
interface gsrl_clr_if;
	logic power_up;
	logic dev_clear;
	logic rl_msg_local;
	logic rl_msg_lockout;
	logic listen_addr;
	modport src (output power_up, output dev_clear, output rl_msg_local,
		output rl_msg_lockout, output listen_addr);
	modport dst (input power_up, input dev_clear, input rl_msg_local,
		input rl_msg_lockout, input listen_addr);
endinterface : gsrl_clr_if

// ### rtl/gsrl_remote_local.sv
// Local, remote and lockout state machine with key lock outputs
`timescale 1ns/100ps
module gsrl_remote_local (
	input wire logic clk,
	input wire logic reset,
	gsrl_clr_if.dst clr,
	input wire logic ren,
	input wire logic local_key,
	input wire logic error_active,
	output gsrl_pkg::gsrl_rl_state_t state,
	output logic keys_locked,
	output logic local_key_locked
);
	gsrl_pkg::gsrl_rl_state_t state_q;
	gsrl_pkg::gsrl_rl_state_t state_d;
	wire go_local = clr.power_up | clr.dev_clear | clr.rl_msg_local | ~ren;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			gsrl_pkg::GSRL_LOCAL:
			begin
				if (ren && clr.listen_addr)
					state_d = clr.rl_msg_lockout ? gsrl_pkg::GSRL_LOCKOUT
						: gsrl_pkg::GSRL_REMOTE;
			end
			gsrl_pkg::GSRL_REMOTE:
			begin
				if (go_local || local_key)
					state_d = gsrl_pkg::GSRL_LOCAL;
				else if (clr.rl_msg_lockout)
					state_d = gsrl_pkg::GSRL_LOCKOUT;
			end
			gsrl_pkg::GSRL_LOCKOUT:
			begin
				if (go_local)
					state_d = gsrl_pkg::GSRL_LOCAL;
			end
			default: state_d = gsrl_pkg::GSRL_LOCAL;
		endcase
		if (clr.power_up || clr.dev_clear)
			state_d = gsrl_pkg::GSRL_LOCAL;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			state_q <= gsrl_pkg::GSRL_LOCAL;
		else
			state_q <= state_d;
	end

	assign state = state_q;
	// Error unlocks the panel under lockout
	assign keys_locked = (state_q != gsrl_pkg::GSRL_LOCAL) &&
		!(state_q == gsrl_pkg::GSRL_LOCKOUT && error_active);
	assign local_key_locked = (state_q == gsrl_pkg::GSRL_LOCKOUT) && !error_active;
endmodule : gsrl_remote_local

// ### verif/gsrl_status_monitor.sv
// Port checker for status reporting and remote/local behaviour
`timescale 1ns/100ps
module gsrl_status_monitor (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic POWER_ON,
	input wire logic [3:0] IF_MSG,
	input wire logic IF_MSG_VALID,
	input wire logic SERIAL_POLL_READ,
	input wire logic [2:0] CMD,
	input wire logic CMD_VALID,
	input wire logic RESP_VALID,
	input wire logic [7:0] POLL_BYTE,
	input wire logic SRQ_N,
	input wire logic SRQ_OE_N,
	input wire logic TALKER,
	input wire logic LISTENER,
	input wire logic FLUSH_BUFFERS,
	input wire logic [1:0] RL_STATE,
	input wire logic KEYS_LOCKED,
	input wire logic LOCAL_KEY_LOCKED
);
	wire dcl_w = IF_MSG_VALID && IF_MSG == gsrl_pkg::MSG_DCL;
	wire ifc_w = IF_MSG_VALID && IF_MSG == gsrl_pkg::MSG_IFC;
	wire ign_w = IF_MSG_VALID && (IF_MSG inside {gsrl_pkg::MSG_PPU, gsrl_pkg::MSG_PPC,
		gsrl_pkg::MSG_GET, gsrl_pkg::MSG_TCT});
	wire qry_w = CMD_VALID && (CMD inside {gsrl_pkg::CMD_ESE_READ, gsrl_pkg::CMD_ESR_READ,
		gsrl_pkg::CMD_SRE_READ, gsrl_pkg::CMD_STB_READ});
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	a_answer_timing: assert property (RESP_VALID == $past(qry_w))
		else $error("answer strobe does not follow query");
	a_srq_pin_use: assert property (!SRQ_N && SRQ_OE_N == !POLL_BYTE[6])
		else $error("request pin disagrees with poll byte");
	a_poll_drops_rqs: assert property (SERIAL_POLL_READ |=> SRQ_OE_N)
		else $error("request kept after poll read");
	a_dcl_flush_local: assert property (dcl_w |=> FLUSH_BUFFERS && RL_STATE == 2'h0 && !LISTENER
		&& !TALKER ##1 !FLUSH_BUFFERS)
		else $error("device clear response wrong");
	a_ifc_keeps_state: assert property (ifc_w |=> !TALKER && !LISTENER && $stable(RL_STATE)
		&& !FLUSH_BUFFERS)
		else $error("interface clear response wrong");
	a_ignored_msg_quiet: assert property (ign_w |=> $stable({RL_STATE, TALKER, LISTENER})
		&& !FLUSH_BUFFERS)
		else $error("ignored message changed state");
	a_power_up_clear: assert property (POWER_ON |=> RL_STATE == 2'h0 && !TALKER && !LISTENER
		&& SRQ_OE_N)
		else $error("power-up state wrong");
	a_state_legal: assert property (RL_STATE != 2'h3)
		else $error("illegal remote/local state");
	a_remote_keys: assert property (RL_STATE == 2'h1 |-> KEYS_LOCKED && !LOCAL_KEY_LOCKED)
		else $error("remote key locks wrong");
	a_local_unlocked: assert property (RL_STATE == 2'h0 |-> !KEYS_LOCKED)
		else $error("keys locked in local");
	cover property (dcl_w);
	cover property ($fell(SRQ_OE_N));
	cover property (RL_STATE == 2'h2);
endmodule : gsrl_status_monitor
bind gsrl_status gsrl_status_monitor u_mon (.CLK, .RESET, .POWER_ON, .IF_MSG, .IF_MSG_VALID,
	.SERIAL_POLL_READ, .CMD, .CMD_VALID, .RESP_VALID, .POLL_BYTE, .SRQ_N, .SRQ_OE_N, .TALKER,
	.LISTENER, .FLUSH_BUFFERS, .RL_STATE, .KEYS_LOCKED, .LOCAL_KEY_LOCKED);

// ### verif/gsrl_ctrl_model.sv
// Bus controller model issuing interface messages and common commands
`timescale 1ns/100ps
module gsrl_ctrl_model (
	input wire logic clk,
	output logic [3:0] if_msg = 4'h5,
	output logic if_msg_valid = 1'b0,
	output logic ren = 1'b0,
	output logic poll_read = 1'b0,
	output logic [2:0] cmd = 3'h2,
	output logic cmd_valid = 1'b0,
	output logic [7:0] cmd_data = 8'hA5,
	output logic cmd_rst = 1'b0
);
	// Code and data turn to their inverse once the strobe drops
	task automatic send_msg(input logic [3:0] c);
		@(posedge clk);
		if_msg <= c;
		if_msg_valid <= 1'b1;
		@(posedge clk);
		if_msg_valid <= 1'b0;
		if_msg <= ~c;
	endtask : send_msg
	// No status byte write; its bits clear through their sources
	task automatic command(input logic [2:0] c, input logic [7:0] d);
		@(posedge clk);
		cmd <= c;
		cmd_data <= d;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd <= ~c;
		cmd_data <= ~d;
	endtask : command
	task automatic strobe(input bit rst_sel);
		@(posedge clk);
		poll_read <= !rst_sel;
		cmd_rst <= rst_sel;
		@(posedge clk);
		poll_read <= 1'b0;
		cmd_rst <= 1'b0;
	endtask : strobe
	task automatic set_ren(input logic v);
		@(posedge clk);
		ren <= v;
	endtask : set_ren
endmodule : gsrl_ctrl_model

// ### verif/gsrl_status_bench.sv
// Self-checking bench for the bus status and remote/local block
`timescale 1ns/100ps
module gsrl_status_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic pwr = 1'b0;
	logic local_bus_exec_error = 1'b0;
	logic local_bus_timeout = 1'b0;
	logic oq = 1'b0;
	logic lkey = 1'b0;
	logic erra = 1'b0;
	logic [3:0] ev = 4'h0;
	logic [3:0] msg;
	logic msg_v, ren, spr, cmd_v, cmd_rst, resp_v, srq_n, srq_oe_n, tal, lis, spm, flush, kl, lkl;
	logic [2:0] cmd;
	logic [7:0] cmd_d, resp, poll, v;
	logic [1:0] rl;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h21D4;
	logic [3:0] ign[5] = '{gsrl_pkg::MSG_PPU, gsrl_pkg::MSG_PPC, gsrl_pkg::MSG_GET,
		gsrl_pkg::MSG_TCT, gsrl_pkg::MSG_GTL};
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	gsrl_status u_dut (.CLK(clk), .RESET(rst), .POWER_ON(pwr), .IF_MSG(msg), .IF_MSG_VALID(msg_v),
		.REN(ren), .SERIAL_POLL_READ(spr), .CMD(cmd), .CMD_VALID(cmd_v), .CMD_RST(cmd_rst),
		.CMD_DATA(cmd_d), .EV_CMD_ERROR(ev[3]), .EV_EXEC_ERROR(ev[2]), .EV_ALARM(ev[1]),
		.EV_OP_COMPLETE(ev[0]), .LOCAL_BUS_EXEC_ERROR(local_bus_exec_error), .LOCAL_BUS_TIMEOUT(local_bus_timeout),
		.OUT_QUEUE_NOT_EMPTY(oq), .LOCAL_KEY(lkey), .ERROR_ACTIVE(erra), .RESP_DATA(resp),
		.RESP_VALID(resp_v), .POLL_BYTE(poll), .SRQ_N(srq_n), .SRQ_OE_N(srq_oe_n), .TALKER(tal),
		.LISTENER(lis), .SERIAL_POLL_MODE(spm), .FLUSH_BUFFERS(flush), .RL_STATE(rl),
		.KEYS_LOCKED(kl), .LOCAL_KEY_LOCKED(lkl));
	gsrl_ctrl_model u_ctrl (.clk(clk), .if_msg(msg), .if_msg_valid(msg_v), .ren(ren),
		.poll_read(spr), .cmd(cmd), .cmd_valid(cmd_v), .cmd_data(cmd_d), .cmd_rst(cmd_rst));
	initial
	begin
		forever #50 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic check(input string nm, input logic [7:0] s, input logic [7:0] e);
		tests_run++;
		if (s !== e)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	task automatic done(input string s);
		$display("Test %s finished", s);
	endtask : done
	task automatic query(input logic [2:0] c, input logic [7:0] e);
		repeat (3) @(posedge clk);
		exp_q.push_back(e);
		u_ctrl.command(c, 8'h00);
	endtask : query
	task automatic pulse_in(input logic [3:0] e, input logic p, input logic k);
		@(posedge clk);
		ev <= e;
		pwr <= p;
		lkey <= k;
		@(posedge clk);
		ev <= 4'h0;
		pwr <= 1'b0;
		lkey <= 1'b0;
	endtask : pulse_in
	task automatic st_chk(input logic [1:0] r, input logic l);
		repeat (2) @(posedge clk);
		#1;
		check("state", {6'h00, rl}, {6'h00, r});
		check("listener", {7'h00, lis}, {7'h00, l});
	endtask : st_chk
	task automatic msg_chk(input logic [3:0] m, input logic [1:0] r, input logic l);
		u_ctrl.send_msg(m);
		st_chk(r, l);
	endtask : msg_chk
	// Answers are matched in order against the noted expectations
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (resp_v === 1'b1)
			check("answer", resp, exp_q.size() ? exp_q.pop_front() : ~resp);
		if (cycles == 5000)
		begin
			miscompares++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		pulse_in(4'h0, 1'b1, 1'b0);
		query(gsrl_pkg::CMD_ESR_READ, 8'h80);
		query(gsrl_pkg::CMD_ESR_READ, 8'h00);
		query(gsrl_pkg::CMD_ESE_READ, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			seed = lfsr(seed);
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : seed[7:0];
			u_ctrl.command(gsrl_pkg::CMD_ESE_WRITE, v);
			query(gsrl_pkg::CMD_ESE_READ, v);
		end
		done("power and mask");
		pulse_in(4'hF, 1'b0, 1'b0);
		query(gsrl_pkg::CMD_ESR_READ, 8'h39);
		u_ctrl.command(gsrl_pkg::CMD_ESE_WRITE, 8'h10);
		u_ctrl.command(gsrl_pkg::CMD_SRE_WRITE, 8'h20);
		pulse_in(4'h4, 1'b0, 1'b0);
		repeat (4) @(posedge clk);
		#1;
		check("poll byte", poll, 8'h60);
		check("request pin", {6'h00, srq_n, srq_oe_n}, 8'h00);
		query(gsrl_pkg::CMD_STB_READ, 8'h60);
		query(gsrl_pkg::CMD_STB_READ, 8'h60);
		u_ctrl.strobe(1'b0);
		@(posedge clk);
		#1;
		check("polled byte", poll, 8'h20);
		query(gsrl_pkg::CMD_ESR_READ, 8'h10);
		query(gsrl_pkg::CMD_STB_READ, 8'h00);
		u_ctrl.command(gsrl_pkg::CMD_SRE_WRITE, 8'hCC);
		local_bus_exec_error <= 1'b1;
		local_bus_timeout <= 1'b1;
		oq <= 1'b1;
		@(posedge clk);
		local_bus_exec_error <= 1'b0;
		local_bus_timeout <= 1'b0;
		query(gsrl_pkg::CMD_STB_READ, 8'h13);
		u_ctrl.command(gsrl_pkg::CMD_SRE_WRITE, 8'h03);
		query(gsrl_pkg::CMD_STB_READ, 8'h53);
		u_ctrl.command(gsrl_pkg::CMD_CLS, 8'h00);
		query(gsrl_pkg::CMD_STB_READ, 8'h10);
		oq <= 1'b0;
		query(gsrl_pkg::CMD_STB_READ, 8'h00);
		done("status byte");
		u_ctrl.set_ren(1'b1);
		msg_chk(gsrl_pkg::MSG_MLA, 2'h1, 1'b1);
		check("keys", {6'h00, kl, lkl}, 8'h02);
		msg_chk(gsrl_pkg::MSG_IFC, 2'h1, 1'b0);
		foreach (ign[i])
			msg_chk(ign[i], 2'h1, 1'b0);
		msg_chk(gsrl_pkg::MSG_MLA, 2'h1, 1'b1);
		msg_chk(gsrl_pkg::MSG_GTL, 2'h0, 1'b1);
		msg_chk(gsrl_pkg::MSG_UNL, 2'h0, 1'b0);
		msg_chk(gsrl_pkg::MSG_LLO, 2'h0, 1'b0);
		msg_chk(gsrl_pkg::MSG_MLA, 2'h2, 1'b1);
		check("lockout keys", {6'h00, kl, lkl}, 8'h03);
		erra <= 1'b1;
		msg_chk(gsrl_pkg::MSG_SPE, 2'h2, 1'b1);
		check("error keys", {7'h00, kl}, 8'h00);
		check("poll mode", {7'h00, spm}, 8'h01);
		erra <= 1'b0;
		msg_chk(gsrl_pkg::MSG_SPD, 2'h2, 1'b1);
		check("poll mode off", {7'h00, spm}, 8'h00);
		msg_chk(gsrl_pkg::MSG_DCL, 2'h0, 1'b0);
		msg_chk(gsrl_pkg::MSG_MTA, 2'h0, 1'b0);
		check("talker", {7'h00, tal}, 8'h01);
		msg_chk(gsrl_pkg::MSG_UNT, 2'h0, 1'b0);
		check("talker off", {7'h00, tal}, 8'h00);
		msg_chk(gsrl_pkg::MSG_MLA, 2'h1, 1'b1);
		u_ctrl.strobe(1'b1);
		st_chk(2'h1, 1'b0);
		query(gsrl_pkg::CMD_ESE_READ, 8'h00);
		pulse_in(4'h0, 1'b0, 1'b1);
		st_chk(2'h0, 1'b0);
		msg_chk(gsrl_pkg::MSG_MLA, 2'h1, 1'b1);
		msg_chk(gsrl_pkg::MSG_SDC, 2'h0, 1'b0);
		done("remote and local");
		repeat (5) @(posedge clk);
		report_and_stop();
	end
endmodule : gsrl_status_bench
